/* inc/old_cfg_pkg.sv */
// Purpose: constants and types for the open-load and overcurrent configuration bank
// Assumes: 8-bit registers on an internal register port of the serial interface
// Notes:   timing figures are in nanoseconds, except DEG_RESET_CYCLES in clock cycles
`default_nettype none
package old_cfg_pkg;
    localparam logic [7:0] ADDR_SLEW_CTRL_SECOND = 8'h1e;
    localparam logic [7:0] ADDR_OL_DISABLE       = 8'h1f;
    localparam logic [7:0] ADDR_OL_REPORT_PAR    = 8'h20;
    localparam logic [7:0] ADDR_OC_FILTER_NEG    = 8'h21;
    localparam logic [7:0] ADDR_LC_OL_ENABLE     = 8'h22;
    localparam logic [7:0] RESET_VALUE           = 8'h00;

    // read-only reserved low nibble of the report register
    localparam logic [7:0] REPORT_WRITE_MASK     = 8'hf0;
    localparam logic [7:0] SLEW2_WRITE_MASK      = 8'hf0;
    localparam logic [7:0] FULL_WRITE_MASK       = 8'hff;

    localparam int REPORT_BIT     = 7;
    localparam int ACTIVE_BIT     = 6;
    localparam int PAR_SLEW_LSB   = 4;
    localparam int DEGLITCH_LSB   = 5;
    localparam int NEG_EN_BIT     = 4;

    localparam logic [1:0] PAR_SLEW_FAST = 2'h0;
    localparam logic [1:0] PAR_SLEW_SLOW = 2'h1;

    localparam int CLK_PERIOD_NS = 5;
    // deglitch times indexed by the field code
    localparam int DEG_NS [8] = '{10000, 5000, 2500, 1000, 60000, 40000, 30000, 20000};
    // code 000 after reset: 10 us at 5 ns per cycle
    localparam logic [19:0] DEG_RESET_CYCLES = 20'h0_07d0;

    typedef struct packed {
        logic [7:0] old_dis;
        logic [7:0] lc_en;
        logic       report_off;
        logic       stay_active;
        logic       slow_par;
        logic       neg_en;
        logic [2:0] deg_sel;
    } cfg_t;
endpackage : old_cfg_pkg
`default_nettype wire

/* rtl/open_load_detect_config_regs.sv */
// Purpose: open-load detection and overcurrent configuration register bank
// Assumes: register port driven by the serial decoder on sys_clk; detector inputs synchronous
// Notes:   fault and active qualifiers are registered, one cycle behind their causes
// How it works
// - set disable bit masks that bridge's check
// - report bit low lets open load pull fault
// - bit 6 low turns bridges off after fault
// - bits 5-4 pick fast or slow slew
// - bits 7-5 pick overcurrent deglitch time
// - bit 4 enables negative-current open load
// - set enable turns on low-current check
// - addresses 0x1F-0x22, all reset to zero
`timescale 1ns/1ps
`default_nettype none
module open_load_detect_config_regs #(
    parameter int BRIDGES = 8
) (
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    output logic      [7:0]         reg_rdata,
    output logic                    reg_addr_err,
    input  wire logic [BRIDGES-1:0] open_load_raw,
    output logic      [BRIDGES-1:0] open_load_check_en,
    output logic      [BRIDGES-1:0] low_current_check_en,
    output logic      [BRIDGES-1:0] bridge_enable,
    output logic                    fault_pin_n,
    output logic                    parallel_turnoff_slow,
    output logic                    negative_current_open_load_en,
    output logic      [19:0]        deglitch_cycles,
    output old_cfg_pkg::cfg_t       cfg
);
    logic                 wr_slew2;
    logic                 wr_dis;
    logic                 wr_rep;
    logic                 wr_ocf;
    logic                 wr_lce;
    logic [7:0]           rep_wdata;
    logic [7:0]           slew2_val;
    logic [7:0]           dis_val;
    logic [7:0]           rep_val;
    logic [7:0]           ocf_val;
    logic [7:0]           lce_val;
    logic [7:0]           rdata_ff;
    logic [7:0]           nxt_rdata;
    logic                 err_ff;
    logic                 nxt_err;
    logic                 fault_n_ff;
    logic                 nxt_fault_n;
    logic                 slow_ff;
    logic                 nxt_slow;
    logic                 neg_ff;
    logic                 nxt_neg;
    logic [19:0]          deg_ff;
    logic [19:0]          nxt_deg;
    old_cfg_pkg::cfg_t    cfg_ff;
    old_cfg_pkg::cfg_t    nxt_cfg;
    logic [BRIDGES-1:0]   bridge_hit;

    // rounds up so a filter is never shorter than the selected time
    function automatic logic [19:0] deg_count(input logic [2:0] sel);
        deg_count = 20'((old_cfg_pkg::DEG_NS[sel] + old_cfg_pkg::CLK_PERIOD_NS - 1)
                        / old_cfg_pkg::CLK_PERIOD_NS);
    endfunction : deg_count

    always_comb begin
        wr_slew2  = reg_wr && (reg_addr == old_cfg_pkg::ADDR_SLEW_CTRL_SECOND);
        wr_dis    = reg_wr && (reg_addr == old_cfg_pkg::ADDR_OL_DISABLE);
        wr_rep    = reg_wr && (reg_addr == old_cfg_pkg::ADDR_OL_REPORT_PAR);
        wr_ocf    = reg_wr && (reg_addr == old_cfg_pkg::ADDR_OC_FILTER_NEG);
        wr_lce    = reg_wr && (reg_addr == old_cfg_pkg::ADDR_LC_OL_ENABLE);
        // invalid slew codes are refused; the field keeps its value, other bits are written
        rep_wdata = reg_wdata;
        if (reg_wdata[old_cfg_pkg::PAR_SLEW_LSB+1]) begin
            rep_wdata[old_cfg_pkg::PAR_SLEW_LSB +: 2] =
                rep_val[old_cfg_pkg::PAR_SLEW_LSB +: 2];
        end
    end

    open_load_cfg_byte #(
        .WRITE_MASK (old_cfg_pkg::SLEW2_WRITE_MASK),
        .RESET_VAL  (old_cfg_pkg::RESET_VALUE)
    ) slew2_reg_i (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .wr_en   (wr_slew2),
        .wdata   (reg_wdata),
        .value   (slew2_val)
    );

    open_load_cfg_byte #(
        .WRITE_MASK (old_cfg_pkg::FULL_WRITE_MASK),
        .RESET_VAL  (old_cfg_pkg::RESET_VALUE)
    ) dis_reg_i (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .wr_en   (wr_dis),
        .wdata   (reg_wdata),
        .value   (dis_val)
    );

    open_load_cfg_byte #(
        .WRITE_MASK (old_cfg_pkg::REPORT_WRITE_MASK),
        .RESET_VAL  (old_cfg_pkg::RESET_VALUE)
    ) rep_reg_i (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .wr_en   (wr_rep),
        .wdata   (rep_wdata),
        .value   (rep_val)
    );

    open_load_cfg_byte #(
        .WRITE_MASK (old_cfg_pkg::FULL_WRITE_MASK),
        .RESET_VAL  (old_cfg_pkg::RESET_VALUE)
    ) ocf_reg_i (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .wr_en   (wr_ocf),
        .wdata   (reg_wdata),
        .value   (ocf_val)
    );

    open_load_cfg_byte #(
        .WRITE_MASK (old_cfg_pkg::FULL_WRITE_MASK),
        .RESET_VAL  (old_cfg_pkg::RESET_VALUE)
    ) lce_reg_i (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .wr_en   (wr_lce),
        .wdata   (reg_wdata),
        .value   (lce_val)
    );

    // a read in the cycle of a write returns the old value
    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_err   = 1'b0;
        if (reg_rd || reg_wr) begin
            case (reg_addr)
                old_cfg_pkg::ADDR_SLEW_CTRL_SECOND: nxt_rdata = slew2_val;
                old_cfg_pkg::ADDR_OL_DISABLE:       nxt_rdata = dis_val;
                old_cfg_pkg::ADDR_OL_REPORT_PAR:    nxt_rdata = rep_val;
                old_cfg_pkg::ADDR_OC_FILTER_NEG:    nxt_rdata = ocf_val;
                old_cfg_pkg::ADDR_LC_OL_ENABLE:     nxt_rdata = lce_val;
                default: begin
                    nxt_rdata = old_cfg_pkg::RESET_VALUE;
                    nxt_err   = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= old_cfg_pkg::RESET_VALUE;
            err_ff   <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            err_ff   <= nxt_err;
        end
    end

    always_comb begin
        nxt_fault_n         = ~((|bridge_hit) & ~rep_val[old_cfg_pkg::REPORT_BIT]);
        nxt_slow            = (rep_val[old_cfg_pkg::PAR_SLEW_LSB +: 2]
                               == old_cfg_pkg::PAR_SLEW_SLOW);
        nxt_neg             = ocf_val[old_cfg_pkg::NEG_EN_BIT];
        nxt_deg             = deg_count(ocf_val[old_cfg_pkg::DEGLITCH_LSB +: 3]);
        nxt_cfg.old_dis     = dis_val;
        nxt_cfg.lc_en       = lce_val;
        nxt_cfg.report_off  = rep_val[old_cfg_pkg::REPORT_BIT];
        nxt_cfg.stay_active = rep_val[old_cfg_pkg::ACTIVE_BIT];
        nxt_cfg.slow_par    = nxt_slow;
        nxt_cfg.neg_en      = nxt_neg;
        nxt_cfg.deg_sel     = ocf_val[old_cfg_pkg::DEGLITCH_LSB +: 3];
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fault_n_ff <= 1'b1;
            slow_ff    <= 1'b0;
            neg_ff     <= 1'b0;
            deg_ff     <= old_cfg_pkg::DEG_RESET_CYCLES;
            cfg_ff     <= '0;
        end else begin
            fault_n_ff <= nxt_fault_n;
            slow_ff    <= nxt_slow;
            neg_ff     <= nxt_neg;
            deg_ff     <= nxt_deg;
            cfg_ff     <= nxt_cfg;
        end
    end

    // one slice per half-bridge; the fault pin sees the slices' next latch state
    for (genvar b = 0; b < BRIDGES; b++) begin : g_bridge
        open_load_bridge_slice bridge_slice_i (
            .sys_clk        (sys_clk),
            .nrst           (nrst),
            .raw            (open_load_raw[b]),
            .check_off      (dis_val[b]),
            .keep_active    (rep_val[old_cfg_pkg::ACTIVE_BIT]),
            .low_current_on (lce_val[b]),
            .hit            (bridge_hit[b]),
            .check_en       (open_load_check_en[b]),
            .low_current_en (low_current_check_en[b]),
            .bridge_on      (bridge_enable[b])
        );
    end

    assign reg_rdata                     = rdata_ff;
    assign reg_addr_err                  = err_ff;
    assign fault_pin_n                   = fault_n_ff;
    assign parallel_turnoff_slow         = slow_ff;
    assign negative_current_open_load_en = neg_ff;
    assign deglitch_cycles               = deg_ff;
    assign cfg                           = cfg_ff;
endmodule : open_load_detect_config_regs

// one configuration byte; bits outside the mask stay zero
module open_load_cfg_byte #(
    parameter logic [7:0] WRITE_MASK = old_cfg_pkg::FULL_WRITE_MASK,
    parameter logic [7:0] RESET_VAL  = old_cfg_pkg::RESET_VALUE
) (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    output logic      [7:0] value
);
    logic [7:0] value_ff;
    logic [7:0] nxt_value;

    always_comb begin
        nxt_value = value_ff;
        if (wr_en) begin
            nxt_value = wdata & WRITE_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            value_ff <= RESET_VAL;
        end else begin
            value_ff <= nxt_value;
        end
    end

    assign value = value_ff;
endmodule : open_load_cfg_byte

// per-bridge open-load latch and qualifiers
module open_load_bridge_slice (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic raw,
    input  wire logic check_off,
    input  wire logic keep_active,
    input  wire logic low_current_on,
    output logic      hit,
    output logic      check_en,
    output logic      low_current_en,
    output logic      bridge_on
);
    logic latched_ff;
    logic nxt_latched;
    logic check_en_ff;
    logic nxt_check_en;
    logic low_current_ff;
    logic nxt_low_current;
    logic bridge_on_ff;
    logic nxt_bridge_on;

    always_comb begin
        nxt_check_en    = ~check_off;
        nxt_low_current = low_current_on;
        // latch clears only by disabling the check or by nrst, so a fault is never lost unseen
        nxt_latched     = (raw | latched_ff) & ~check_off;
        nxt_bridge_on   = keep_active | ~nxt_latched;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            latched_ff     <= 1'b0;
            check_en_ff    <= 1'b1;
            low_current_ff <= 1'b0;
            bridge_on_ff   <= 1'b1;
        end else begin
            latched_ff     <= nxt_latched;
            check_en_ff    <= nxt_check_en;
            low_current_ff <= nxt_low_current;
            bridge_on_ff   <= nxt_bridge_on;
        end
    end

    assign hit            = nxt_latched;
    assign check_en       = check_en_ff;
    assign low_current_en = low_current_ff;
    assign bridge_on      = bridge_on_ff;
endmodule : open_load_bridge_slice
`default_nettype wire

/* dv/old_host.sv */
// Purpose: host model of the register port
// Assumes: one access per call, moved 1 ns after the rising edge
// Notes:   released address and data are inverted so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module old_host (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    task automatic acc(input logic w, input logic [7:0] a, dw, output logic [7:0] q);
        @(posedge sys_clk) #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, dw};
        @(posedge sys_clk) #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~dw};
        q = reg_rdata;
    endtask : acc
endmodule : old_host
`default_nettype wire

/* dv/old_cfg_chk.sv */
// Purpose: port assertions for the open-load configuration bank
// Assumes: single sys_clk domain, nrst active low
// Notes:   write-driven outputs settle two edges after the write edge
`timescale 1ns/1ps
`default_nettype none
module old_cfg_chk #(
    parameter int BRIDGES = 8
) (
    input wire logic               sys_clk,
    input wire logic               nrst,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic               reg_addr_err,
    input wire logic               fault_pin_n,
    input wire logic               parallel_turnoff_slow,
    input wire logic               negative_current_open_load_en,
    input wire logic [7:0]         reg_addr,
    input wire logic [7:0]         reg_wdata,
    input wire logic [7:0]         reg_rdata,
    input wire logic [BRIDGES-1:0] open_load_check_en,
    input wire logic [BRIDGES-1:0] bridge_enable,
    input wire logic [19:0]        deglitch_cycles,
    input wire old_cfg_pkg::cfg_t  cfg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_check_en_map: assert property (reg_wr && reg_addr == 8'h1f ##1 !reg_wr
        |=> open_load_check_en == ~$past(reg_wdata, 2)) else $error("check enable wrong");
    a_fault_report: assert property (cfg.report_off [*2] |-> fault_pin_n)
        else $error("fault pin low while reporting off");
    a_stay_active: assert property (cfg.stay_active [*2] |-> bridge_enable == '1)
        else $error("bridge off while kept active");
    a_slow_code: assert property (reg_wr && reg_addr == 8'h20 && reg_wdata[5:4] == 2'h1
        |-> ##2 parallel_turnoff_slow) else $error("slow slew not selected");
    a_bad_code: assert property (reg_wr && reg_addr == 8'h20 && reg_wdata[5]
        |-> ##2 $stable(parallel_turnoff_slow)) else $error("invalid slew code taken");
    a_deg_code: assert property (reg_wr && reg_addr == 8'h21 && reg_wdata[7:5] == 3'h3
        |-> ##2 deglitch_cycles == 20'h0_00c8) else $error("deglitch count wrong");
    a_neg_follow: assert property (reg_wr && reg_addr == 8'h21
        |-> ##2 negative_current_open_load_en == $past(reg_wdata[4], 2)) else $error("neg mode");
    a_unmapped_err: assert property (reg_rd && reg_addr == 8'h23
        |=> reg_addr_err && reg_rdata == 8'h00) else $error("unmapped read not flagged");
endmodule : old_cfg_chk
bind open_load_detect_config_regs old_cfg_chk #(
    .BRIDGES(BRIDGES)
) old_cfg_chk_i (
    .sys_clk                       (sys_clk),
    .nrst                          (nrst),
    .reg_wr                        (reg_wr),
    .reg_rd                        (reg_rd),
    .reg_addr_err                  (reg_addr_err),
    .fault_pin_n                   (fault_pin_n),
    .parallel_turnoff_slow         (parallel_turnoff_slow),
    .negative_current_open_load_en (negative_current_open_load_en),
    .reg_addr                      (reg_addr),
    .reg_wdata                     (reg_wdata),
    .reg_rdata                     (reg_rdata),
    .open_load_check_en            (open_load_check_en),
    .bridge_enable                 (bridge_enable),
    .deglitch_cycles               (deglitch_cycles),
    .cfg                           (cfg)
);
`default_nettype wire

/* dv/test_open_load_detect_config_regs.sv */
// Purpose: register-port tests of the open-load configuration bank
// Assumes: host model drives the port 1 ns after each rising edge
// Notes:   deglitch counts derived from the package table
`timescale 1ns/1ps
`default_nettype none
module test_open_load_detect_config_regs;
    logic sys_clk, nrst, reg_wr, reg_rd, reg_addr_err, fault_pin_n, parallel_turnoff_slow;
    logic negative_current_open_load_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, open_load_raw, open_load_check_en, d;
    logic [7:0] low_current_check_en, bridge_enable;
    logic [19:0] deglitch_cycles;
    old_cfg_pkg::cfg_t cfg;
    int fails, checks;
    open_load_detect_config_regs open_load_detect_config_regs_i (
        .sys_clk                       (sys_clk),
        .nrst                          (nrst),
        .reg_wr                        (reg_wr),
        .reg_rd                        (reg_rd),
        .reg_addr                      (reg_addr),
        .reg_wdata                     (reg_wdata),
        .reg_rdata                     (reg_rdata),
        .reg_addr_err                  (reg_addr_err),
        .open_load_raw                 (open_load_raw),
        .open_load_check_en            (open_load_check_en),
        .low_current_check_en          (low_current_check_en),
        .bridge_enable                 (bridge_enable),
        .fault_pin_n                   (fault_pin_n),
        .parallel_turnoff_slow         (parallel_turnoff_slow),
        .negative_current_open_load_en (negative_current_open_load_en),
        .deglitch_cycles               (deglitch_cycles),
        .cfg                           (cfg)
    );
    old_host old_host_i (
        .sys_clk   (sys_clk),
        .reg_rdata (reg_rdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata)
    );
    task automatic chk(input logic [19:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task automatic s();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : s
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        #20000;
        fails++;
        end_sim();
    end
    initial begin
        {nrst, open_load_raw} = '0;
        repeat (12) @(posedge sys_clk);
        #1 nrst = 1'b1;
        chk(open_load_check_en, 8'hff);
        chk(low_current_check_en, 8'h00);
        chk(bridge_enable, 8'hff);
        chk(fault_pin_n, 1'b1);
        chk(deglitch_cycles, 20'(old_cfg_pkg::DEG_NS[0] / old_cfg_pkg::CLK_PERIOD_NS));
        for (int i = 0; i < 6; i++) begin
            old_host_i.acc(1'b0, 8'h1e + 8'(i), 8'h00, d);
            chk(d, 8'h00);
            chk(reg_addr_err, i == 5);
        end
        old_host_i.acc(1'b1, 8'h1f, 8'h01, d);
        old_host_i.acc(1'b1, 8'h22, 8'ha5, d);
        old_host_i.acc(1'b1, 8'h20, 8'h10, d);
        s();
        chk(open_load_check_en, 8'hfe);
        chk(low_current_check_en, 8'ha5);
        chk(parallel_turnoff_slow, 1'b1);
        // bit 5 set: slew field must keep 01, other bits still written
        old_host_i.acc(1'b1, 8'h20, 8'h2f, d);
        old_host_i.acc(1'b0, 8'h20, 8'h00, d);
        chk(d, 8'h10);
        for (int i = 0; i < 8; i++) begin
            old_host_i.acc(1'b1, 8'h21, {3'(i), 5'h1f}, d);
            s();
            chk(deglitch_cycles, 20'(old_cfg_pkg::DEG_NS[i] / old_cfg_pkg::CLK_PERIOD_NS));
            chk(negative_current_open_load_en, 1'b1);
        end
        old_host_i.acc(1'b1, 8'h21, 8'h0f, d);
        old_host_i.acc(1'b0, 8'h21, 8'h00, d);
        chk(d, 8'h0f);
        chk(negative_current_open_load_en, 1'b0);
        old_host_i.acc(1'b1, 8'h20, 8'h00, d);
        // bridge 1 has its check disabled, so only bridge 2 may latch
        open_load_raw = 8'h03;
        s();
        chk(fault_pin_n, 1'b0);
        chk(bridge_enable, 8'hfd);
        old_host_i.acc(1'b1, 8'h20, 8'hc0, d);
        s();
        chk(fault_pin_n, 1'b1);
        chk(bridge_enable, 8'hff);
        chk(parallel_turnoff_slow, 1'b0);
        chk(cfg.old_dis, 8'h01);
        chk(cfg.lc_en, 8'ha5);
        chk(cfg.report_off, 1'b1);
        chk(cfg.stay_active, 1'b1);
        chk(cfg.slow_par, 1'b0);
        chk(cfg.deg_sel, 3'h0);
        chk(cfg.neg_en, 1'b0);
        // mid-run reset: registers and qualifiers return to their reset values
        open_load_raw = 8'h00;
        nrst = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 nrst = 1'b1;
        old_host_i.acc(1'b0, 8'h20, 8'h00, d);
        chk(d, 8'h00);
        old_host_i.acc(1'b0, 8'h1f, 8'h00, d);
        chk(d, 8'h00);
        chk(open_load_check_en, 8'hff);
        chk(deglitch_cycles, 20'(old_cfg_pkg::DEG_NS[0] / old_cfg_pkg::CLK_PERIOD_NS));
        end_sim();
    end
endmodule : test_open_load_detect_config_regs
`default_nettype wire
